// file: inc/fhcr_pkg.sv
// Purpose: Shared constants for the frontend host control register bank.
// Assumes: Byte-wide register port, one access per cycle on the mclk clock.
// Notes: Offsets are register addresses on the documented register port.
// Functional notes
// RL1: Command bit 7 set enters power-down.
// RL2: Command bit 6 powers down radio paths.
// RL3: Command bits 4..0 hold command code.
// RL4: Ownership register changes only after unlock.
// RL5: Next write clears unlock bit automatically.
// RL6: Bit 6 gives bus to host.
// RL7: Bit 5 gives bus to secure module.
// RL8: Both ownership bits never one together.
// RL9: Ownership bits set only after prior unlock.
// RL10: Link select: off, SPI, slow I2C, I2C.
// RL11: Depth select: one 255, zero 512.
// RL12: Software should clear buffer before resizing.
// RL13: Near-full when capacity minus count below threshold; the code also sets it when the two are equal.
// RL14: Near-empty when count at most threshold.
// RL15: Clear bit empties buffer, reads zero.
// RL16: Bit 2 is threshold bit 8, 512 only.
// RL17: Bits 1..0 give count bits 9..8.
// RL18: Data write increments, data read decrements count.
// RL19: Setting both ownership bits keeps old values.
package fhcr_pkg;
  // Register addresses.
  localparam logic [7:0] ADDR_COMMAND = 8'h00;
  localparam logic [7:0] ADDR_OWNERSHIP = 8'h01;
  localparam logic [7:0] ADDR_BUF_CTRL = 8'h02;
  localparam logic [7:0] ADDR_THRESHOLD = 8'h03;
  localparam logic [7:0] ADDR_BYTE_COUNT = 8'h04;
  localparam logic [7:0] ADDR_DATA_PORT = 8'h05;
  // Command register fields.
  localparam int CMD_POWER_DOWN_BIT = 7;
  localparam int CMD_RADIO_OFF_BIT = 6;
  localparam int CMD_CODE_MSB = 4;
  // Ownership register fields.
  localparam int OWN_UNLOCK_BIT = 7;
  localparam int OWN_HOST_BIT = 6;
  localparam int OWN_MODULE_BIT = 5;
  localparam int OWN_LINK_MSB = 3;
  localparam int OWN_LINK_LSB = 2;
  // Buffer control fields.
  localparam int BC_DEPTH_BIT = 7;
  localparam int BC_NEAR_FULL_BIT = 6;
  localparam int BC_NEAR_EMPTY_BIT = 5;
  localparam int BC_CLEAR_BIT = 4;
  localparam int BC_THRESH8_BIT = 2;
  // Capacities and storage size.
  localparam logic [9:0] DEPTH_SMALL = 10'h0ff;
  localparam logic [9:0] DEPTH_LARGE = 10'h200;
  localparam int STORE_WORDS = 512;
  // Reset values.
  localparam logic [7:0] RESET_COMMAND = 8'h00;
  localparam logic [7:0] RESET_OWNERSHIP = 8'h00;
  localparam logic [7:0] RESET_THRESHOLD = 8'h00;
  localparam logic RESET_DEPTH = 1'b0;
  // Secure-module link selections.
  typedef enum logic [1:0] {
    FHCR_LINK_OFF,
    FHCR_LINK_SPI,
    FHCR_LINK_I2C_SLOW,
    FHCR_LINK_I2C
  } fhcr_link_t;
endpackage

// file: design/fhcr_buffer.sv
// Purpose: Byte buffer with selectable capacity and a live byte count.
// Assumes: Push and pop are single-cycle strobes from the register decode.
// Notes: Overrun and underrun attempts are ignored.
`timescale 1ns/10ps
module fhcr_buffer
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Control.
  input wire logic small_depth,
  input wire logic clear,
  // Data.
  input wire logic push,
  input wire logic [7:0] push_data,
  input wire logic pop,
  output logic [7:0] pop_data,
  output logic [9:0] count
);
  logic [7:0] mem [fhcr_pkg::STORE_WORDS];
  logic [8:0] wr_ptr_r;
  logic [8:0] rd_ptr_r;
  logic [9:0] count_r;
  logic [9:0] cap;
  logic do_push;
  logic do_pop;

  // Capacity follows the depth select live.
  always_comb
  begin
    cap = small_depth ? fhcr_pkg::DEPTH_SMALL
                      : fhcr_pkg::DEPTH_LARGE; // see RL11
    do_push = push && !clear && (count_r < cap);
    do_pop = pop && !clear && (count_r != 10'h000);
  end

  // Storage write; no reset needed on the array.
  always_ff @(posedge mclk)
  begin
    if (do_push)
      mem[wr_ptr_r] <= push_data;
  end

  // Pointers and count; clear wins over traffic.
  always_ff @(posedge mclk)
  begin
    if (reset || clear) // see RL15
    begin
      wr_ptr_r <= 9'h000;
      rd_ptr_r <= 9'h000;
      count_r <= 10'h000;
    end
    else
    begin
      if (do_push)
        wr_ptr_r <= wr_ptr_r + 9'h001;
      if (do_pop)
        rd_ptr_r <= rd_ptr_r + 9'h001;
      if (do_push && !do_pop)
        count_r <= count_r + 10'h001; // see RL18
      else if (do_pop && !do_push)
        count_r <= count_r - 10'h001; // see RL18
    end
  end

  assign pop_data = mem[rd_ptr_r];
  assign count = count_r;
endmodule

// file: design/fhcr_regs.sv
// Purpose: Host register bank for command, bus ownership and buffer control.
// Assumes: Register port gives a one-cycle strobe per read or write.
// Notes: Read data is registered and appears one cycle after the strobe.
`timescale 1ns/10ps
module fhcr_regs
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Power and command.
  output logic power_down,
  output logic radio_path_power_down,
  output logic [4:0] command_code,
  output logic command_strobe,
  // Bus ownership.
  output logic host_owns_bus,
  output logic secure_module_owns_bus,
  output logic [1:0] secure_module_link_select,
  // Buffer status.
  output logic near_full_flag,
  output logic near_empty_flag
);
  logic [7:0] cmd_r;
  logic unlock_r;
  logic host_r;
  logic module_r;
  logic [1:0] link_r;
  logic depth_r;
  logic [8:0] thresh_r;
  logic [7:0] rdata_r;
  logic cmd_stb_r;
  logic near_full_r;
  logic near_empty_r;
  logic [9:0] count;
  logic [7:0] pop_data;
  logic [9:0] cap;
  logic [9:0] thresh_eff;
  logic [9:0] count_eff;
  logic [7:0] ctrl_view;
  logic [7:0] own_view;
  logic wr_cmd;
  logic wr_own;
  logic wr_bc;
  logic wr_th;
  logic push;
  logic pop;
  logic clear;

  // Address match on a strobe; shared by every decode below.
  function automatic logic hit(input logic stb, input logic [7:0] a,
                               input logic [7:0] want);
    hit = stb && (a == want);
  endfunction

  // Write and read decode.
  always_comb
  begin
    wr_cmd = hit(reg_wr, reg_addr, fhcr_pkg::ADDR_COMMAND);
    wr_own = hit(reg_wr, reg_addr, fhcr_pkg::ADDR_OWNERSHIP);
    wr_bc = hit(reg_wr, reg_addr, fhcr_pkg::ADDR_BUF_CTRL);
    wr_th = hit(reg_wr, reg_addr, fhcr_pkg::ADDR_THRESHOLD);
    push = hit(reg_wr, reg_addr, fhcr_pkg::ADDR_DATA_PORT); // see RL18
    pop = hit(reg_rd, reg_addr, fhcr_pkg::ADDR_DATA_PORT); // see RL18
    clear = wr_bc && reg_wdata[fhcr_pkg::BC_CLEAR_BIT]; // see RL15
  end

  // Buffer storage and byte counter.
  fhcr_buffer u_buffer
  (
    .mclk(mclk),
    .reset(reset),
    .small_depth(depth_r),
    .clear(clear),
    .push(push),
    .push_data(reg_wdata),
    .pop(pop),
    .pop_data(pop_data),
    .count(count)
  );

  // Command register; bit 5 is reserved and never stored.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      cmd_r <= fhcr_pkg::RESET_COMMAND;
      cmd_stb_r <= 1'b0;
    end
    else
    begin
      cmd_stb_r <= wr_cmd; // see RL3
      if (wr_cmd)
      begin
        cmd_r[fhcr_pkg::CMD_POWER_DOWN_BIT] <=
          reg_wdata[fhcr_pkg::CMD_POWER_DOWN_BIT]; // see RL1
        cmd_r[fhcr_pkg::CMD_RADIO_OFF_BIT] <=
          reg_wdata[fhcr_pkg::CMD_RADIO_OFF_BIT]; // see RL2
        cmd_r[fhcr_pkg::CMD_CODE_MSB:0] <=
          reg_wdata[fhcr_pkg::CMD_CODE_MSB:0]; // see RL3
      end
    end
  end

  // Unlock bit: any write to any register consumes a standing unlock.
  always_ff @(posedge mclk)
  begin
    if (reset)
      unlock_r <= fhcr_pkg::RESET_OWNERSHIP[fhcr_pkg::OWN_UNLOCK_BIT];
    else if (reg_wr)
    begin
      if (unlock_r)
        unlock_r <= 1'b0; // see RL5
      else if (wr_own)
        unlock_r <= reg_wdata[fhcr_pkg::OWN_UNLOCK_BIT]; // see RL4
    end
  end

  // Ownership and link fields change only on the write after an unlock.
  // The write that sets the unlock itself changes nothing else, which
  // keeps a stray single write from moving bus ownership.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      host_r <= fhcr_pkg::RESET_OWNERSHIP[fhcr_pkg::OWN_HOST_BIT];
      module_r <= fhcr_pkg::RESET_OWNERSHIP[fhcr_pkg::OWN_MODULE_BIT];
      link_r <= fhcr_pkg::RESET_OWNERSHIP[fhcr_pkg::OWN_LINK_MSB:
                                           fhcr_pkg::OWN_LINK_LSB];
    end
    else if (wr_own && unlock_r) // see RL4, RL9
    begin
      link_r <= reg_wdata[fhcr_pkg::OWN_LINK_MSB:
                          fhcr_pkg::OWN_LINK_LSB]; // see RL10
      if (!(reg_wdata[fhcr_pkg::OWN_HOST_BIT] &&
            reg_wdata[fhcr_pkg::OWN_MODULE_BIT])) // see RL8, RL19
      begin
        host_r <= reg_wdata[fhcr_pkg::OWN_HOST_BIT]; // see RL6
        module_r <= reg_wdata[fhcr_pkg::OWN_MODULE_BIT]; // see RL7
      end
    end
  end

  // Depth select and threshold; threshold bit 8 lives in buffer control.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      depth_r <= fhcr_pkg::RESET_DEPTH;
      thresh_r <= {1'b0, fhcr_pkg::RESET_THRESHOLD};
    end
    else
    begin
      if (wr_bc)
      begin
        depth_r <= reg_wdata[fhcr_pkg::BC_DEPTH_BIT]; // see RL11
        thresh_r[8] <= reg_wdata[fhcr_pkg::BC_THRESH8_BIT]; // see RL16
      end
      if (wr_th)
        thresh_r[7:0] <= reg_wdata;
    end
  end

  // Extension bits count only in the large mode; in the small mode the
  // threshold and count are limited to their low eight bits.
  always_comb
  begin
    cap = depth_r ? fhcr_pkg::DEPTH_SMALL : fhcr_pkg::DEPTH_LARGE;
    thresh_eff = depth_r ? {2'b00, thresh_r[7:0]}
                         : {1'b0, thresh_r}; // see RL16
    count_eff = depth_r ? {2'b00, count[7:0]} : count; // see RL17
  end

  // Alert flags are registered so the outputs come from flip-flops.
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      near_full_r <= 1'b0;
      near_empty_r <= 1'b0;
    end
    else
    begin
      near_full_r <= (cap - count_eff) <= thresh_eff; // see RL13
      near_empty_r <= count_eff <= thresh_eff; // see RL14
    end
  end

  // Read views; the clear bit and reserved bits always read zero.
  always_comb
  begin
    own_view = {unlock_r, host_r, module_r, 1'b0, link_r, 2'b00};
    ctrl_view = {depth_r, near_full_r, near_empty_r, 1'b0, 1'b0,
                 thresh_r[8], count_eff[9:8]}; // see RL15, RL17
  end

  // Registered read mux; unmapped addresses read zero.
  always_ff @(posedge mclk)
  begin
    if (reset)
      rdata_r <= 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        fhcr_pkg::ADDR_COMMAND: rdata_r <= {cmd_r[7:6], 1'b0, cmd_r[4:0]};
        fhcr_pkg::ADDR_OWNERSHIP: rdata_r <= own_view;
        fhcr_pkg::ADDR_BUF_CTRL: rdata_r <= ctrl_view;
        fhcr_pkg::ADDR_THRESHOLD: rdata_r <= thresh_r[7:0];
        fhcr_pkg::ADDR_BYTE_COUNT: rdata_r <= count[7:0];
        fhcr_pkg::ADDR_DATA_PORT: rdata_r <= pop_data;
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  // Outputs.
  assign reg_rdata = rdata_r;
  assign power_down = cmd_r[fhcr_pkg::CMD_POWER_DOWN_BIT]; // see RL1
  assign radio_path_power_down =
    cmd_r[fhcr_pkg::CMD_RADIO_OFF_BIT]; // see RL2
  assign command_code = cmd_r[fhcr_pkg::CMD_CODE_MSB:0];
  assign command_strobe = cmd_stb_r;
  assign host_owns_bus = host_r;
  assign secure_module_owns_bus = module_r;
  assign secure_module_link_select = link_r;
  assign near_full_flag = near_full_r;
  assign near_empty_flag = near_empty_r;
endmodule

// file: tb/fhcr_regs_asserts.sv
// Purpose: Port checks of the host control register bank.
// Assumes: One access per cycle; reset is synchronous, active high.
// Notes: Bound to every fhcr_regs instance.
`timescale 1ns/10ps
module fhcr_regs_chk
(
  // Clock, reset and register port.
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Outputs under watch.
  input wire logic power_down,
  input wire logic radio_path_power_down,
  input wire logic [4:0] command_code,
  input wire logic command_strobe,
  input wire logic host_owns_bus,
  input wire logic secure_module_owns_bus,
  input wire logic [1:0] secure_module_link_select,
  input wire logic near_full_flag,
  input wire logic near_empty_flag
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  // Decoded accesses that the properties start from.
  wire cmd_wr = reg_wr && (reg_addr == 8'h00);
  wire own_wr = reg_wr && (reg_addr == 8'h01);
  wire clr_wr = reg_wr && (reg_addr == 8'h02) && reg_wdata[4];
  wire ctl_rd = reg_rd && (reg_addr == 8'h02);
  wire own_rd = reg_rd && (reg_addr == 8'h01);
  logic unl_r;

  // Unlock as software sees it; any write spends a standing unlock.
  always_ff @(posedge mclk)
  begin
    if (reset)
      unl_r <= 1'b0;
    else if (reg_wr)
      unl_r <= !unl_r && own_wr && reg_wdata[7];
  end

  pd_follow_a: assert property (
    cmd_wr |=> power_down == $past(reg_wdata[7]))
    else $error("power_down does not follow the command write");
  pd_hold_a: assert property (
    !cmd_wr |=> $stable(power_down))
    else $error("power_down changed without a command write");
  radio_off_a: assert property (
    cmd_wr |=> radio_path_power_down == $past(reg_wdata[6]))
    else $error("radio power-down does not follow bit 6");
  cmd_code_a: assert property (
    cmd_wr |=> command_code == $past(reg_wdata[4:0]))
    else $error("command code does not follow bits 4..0");
  cmd_stb_a: assert property (
    command_strobe == $past(cmd_wr))
    else $error("command strobe does not follow the command write");
  own_excl_a: assert property (
    !(host_owns_bus && secure_module_owns_bus))
    else $error("both ownership bits are set");
  own_rise_a: assert property (
    $rose(host_owns_bus) || $rose(secure_module_owns_bus) |->
      $past(own_wr))
    else $error("ownership rose without an ownership write");
  own_lock_a: assert property (
    $changed({host_owns_bus, secure_module_owns_bus}) |->
      $past(own_wr && unl_r))
    else $error("ownership changed without a prior unlock");
  unlock_view_a: assert property (
    own_rd |=> reg_rdata[7] == $past(unl_r))
    else $error("unlock bit read back wrong");
  link_write_a: assert property (
    $changed(secure_module_link_select) |-> $past(own_wr))
    else $error("link select changed without an ownership write");
  clear_empty_a: assert property (
    clr_wr |-> ##2 near_empty_flag)
    else $error("near-empty not shown after a clear");
  clear_reads_a: assert property (
    ctl_rd |=> !reg_rdata[4])
    else $error("clear bit read back as one");
  host_cov: cover property ($rose(host_owns_bus));
  module_cov: cover property ($rose(secure_module_owns_bus));
  full_cov: cover property ($rose(near_full_flag));
endmodule
bind fhcr_regs fhcr_regs_chk u_chk(.mclk(mclk), .reset(reset),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .power_down(power_down),
  .radio_path_power_down(radio_path_power_down),
  .command_code(command_code), .command_strobe(command_strobe),
  .host_owns_bus(host_owns_bus),
  .secure_module_owns_bus(secure_module_owns_bus),
  .secure_module_link_select(secure_module_link_select),
  .near_full_flag(near_full_flag), .near_empty_flag(near_empty_flag));

// file: tb/fhcr_host.sv
// Purpose: Host microcontroller model on the register port.
// Assumes: Strobes last one cycle and change 1 ns after the edge.
// Notes: Released address and data lines show the inverse of the last value.
`timescale 1ns/10ps
module fhcr_host
(
  // Clock and read-back.
  input wire logic mclk,
  input wire logic [7:0] reg_rdata,
  // Requests.
  output logic [7:0] reg_addr,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_wdata
);
  // Idle bus at time zero.
  initial
  begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // One access; read data is taken 1 ns after the edge that samples the read strobe.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(posedge mclk);
    #1;
    q = reg_rdata;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // Unlock first, because a bare ownership write is refused.
  task automatic own_set(input logic [7:0] d);
    logic [7:0] q;
    xfer(1'b1, 8'h01, 8'h80, q);
    xfer(1'b1, 8'h01, d, q);
  endtask
endmodule

// file: tb/testbench.sv
// Purpose: Self-checking bench of the host control register bank.
// Assumes: Register port driven by the host model.
// Notes: Random data comes from a bench shift register.
`timescale 1ns/10ps
module testbench;
  logic mclk;
  logic reset;
  logic [31:0] seed;
  logic [7:0] q;
  logic [7:0] v;
  logic [7:0] sent [3];
  int fails;
  int n_checks;
  int i;
  wire [7:0] reg_addr, reg_wdata, reg_rdata;
  wire reg_wr, reg_rd, pd, rpd, strobe, hob, smob, nf, ne;
  wire [4:0] code;
  wire [1:0] link;
  wire [7:0] cmd = {pd, rpd, 1'b0, code};
  wire [7:0] own = {4'h0, hob, smob, link};
  fhcr_host host(.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
  fhcr_regs DUT(.mclk(mclk), .reset(reset), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .power_down(pd), .radio_path_power_down(rpd),
    .command_code(code), .command_strobe(strobe), .host_owns_bus(hob),
    .secure_module_owns_bus(smob), .secure_module_link_select(link),
    .near_full_flag(nf), .near_empty_flag(ne));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Buffer control read-back; extension bits only count in 512 mode.
  function automatic logic [7:0] ctrl_exp(input logic sm, input int c,
                                          input int t);
    int cap;
    cap = sm ? 255 : 512;
    return {sm, (cap - c) <= t, c <= t, 2'b00, sm ? 1'b0 : t[8],
            sm ? 2'b00 : c[9:8]};
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Write; the read-back of a write is dropped so no stimulus is clobbered.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    host.xfer(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host.xfer(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Free-running 100 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // The run needs about six hundred cycles; this cuts a hang short.
  initial
  begin
    #100000;
    fails++;
    close_out();
  end
  // Main sequence.
  initial
  begin
    fails = 0;
    n_checks = 0;
    seed = 32'h5fd5a544;
    reset = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    reset = 1'b0;
    rd_chk(8'h02, ctrl_exp(1'b0, 0, 0));
    rd_chk(8'h60, 8'h00);
    for (i = 0; i < 6; i++)
    begin
      seed = lfsr(seed);
      v = (i == 0) ? 8'hff : ((i == 1) ? 8'h00 : seed[7:0]);
      wr(8'h00, v);
      chk(cmd, {v[7:6], 1'b0, v[4:0]});
      chk({7'h00, strobe}, 8'h01);
    end
    rd_chk(8'h00, {v[7:6], 1'b0, v[4:0]});
    chk({7'h00, strobe}, 8'h00);
    $display("test command done");
    wr(8'h01, 8'h44);
    chk(own, 8'h00);
    host.own_set(8'h44);
    chk(own, 8'h09);
    rd_chk(8'h01, 8'h44);
    wr(8'h01, 8'h20);
    chk(own, 8'h09);
    wr(8'h01, 8'h80);
    rd_chk(8'h01, 8'hc4);
    wr(8'h03, 8'h00);
    wr(8'h01, 8'h20);
    chk(own, 8'h09);
    host.own_set(8'h60);
    chk(own, 8'h08);
    for (i = 0; i < 4; i++)
    begin
      host.own_set({4'h2, i[1:0], 2'b00});
      chk(own, {6'h01, i[1:0]});
    end
    $display("test ownership done");
    wr(8'h03, 8'hfe);
    wr(8'h02, 8'h90);
    rd_chk(8'h02, ctrl_exp(1'b1, 0, 254));
    rd_chk(8'h03, 8'hfe);
    chk({6'h00, nf, ne}, 8'h01);
    seed = lfsr(seed);
    wr(8'h05, seed[7:0]);
    rd_chk(8'h02, ctrl_exp(1'b1, 1, 254));
    $display("test small depth done");
    wr(8'h02, 8'h14);
    rd_chk(8'h02, ctrl_exp(1'b0, 0, 510));
    for (i = 0; i < 258; i++)
    begin
      seed = lfsr(seed);
      if (i < 3)
        sent[i] = seed[7:0];
      wr(8'h05, seed[7:0]);
    end
    rd_chk(8'h04, 8'h02);
    rd_chk(8'h02, ctrl_exp(1'b0, 258, 510));
    chk({6'h00, nf, ne}, 8'h03);
    // The oldest bytes come out first, in the order they went in.
    for (i = 0; i < 3; i++)
      rd_chk(8'h05, sent[i]);
    rd_chk(8'h04, 8'hff);
    rd_chk(8'h02, ctrl_exp(1'b0, 255, 510));
    $display("test large depth done");
    close_out();
  end
endmodule
